/* File: gpc_defs.vh */
// gpc_defs.vh: offsets, fields, reset values and counts of the pin 3 block.
// assumes a 16-bit register port.
`ifndef GPC_DEFS_VH
`define GPC_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define GPC_ADDR_CTRL        16'h403a
`define GPC_ADDR_DATA        16'h4044
`define GPC_ADDR_IRQ_STAT    16'h4045
`define GPC_ADDR_IRQ_MASK    16'h4046

// ----------------------------------------
// control register fields
// ----------------------------------------
`define GPC_BIT_DIR          15
`define GPC_PULL_HI          14
`define GPC_PULL_LO          13
`define GPC_BIT_IRQ_MODE     12
`define GPC_BIT_SUPPLY       11
`define GPC_BIT_POL          10
`define GPC_BIT_OD           9
`define GPC_BIT_ENA          7
`define GPC_FN_HI            3
`define GPC_FN_LO            0
`define GPC_CTRL_RESET       16'ha400
`define GPC_CTRL_WMASK       16'hfe8f

// pull codes
`define GPC_PULL_NONE        2'h0
`define GPC_PULL_DOWN        2'h1
`define GPC_PULL_UP          2'h2

// ----------------------------------------
// data, status and mask fields
// ----------------------------------------
`define GPC_BIT_OUT_LVL      0
`define GPC_BIT_IN_LVL       1
`define GPC_BIT_EDGE_EVT     0

// ----------------------------------------
// timing
// ----------------------------------------
`define GPC_LONG_DB_CYC      20'h3d090  // 1 ms at 250 MHz
`define GPC_DB_CNT_W         20

`endif

/* File: gpc_sync.v */
// gpc_sync.v: three-stage synchroniser with agreement filter for a pin.
// assumes the input is asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

module gpc_sync (
    input  wire core_clk,   // block clock
    input  wire rst_n,      // synchronous reset, active low
    input  wire asyncIn,    // raw pin level
    output reg  syncLvl_r   // filtered level
);

    reg stage1_r;
    reg stage2_r;
    reg stage3_r;

    // ------------------------------------------------------------------
    // three flops; the level changes only once stages two and three agree
    // ------------------------------------------------------------------
    // stage1 feeds stage2 alone, to keep metastability out of the compare
    always @(posedge core_clk) begin
        if (!rst_n) begin
            stage1_r  <= 1'b0;
            stage2_r  <= 1'b0;
            stage3_r  <= 1'b0;
            syncLvl_r <= 1'b0;
        end else begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            if (stage2_r == stage3_r) begin
                syncLvl_r <= stage3_r;
            end
        end
    end

endmodule // gpc_sync

`default_nettype wire

/* File: gpc_pin_control.v */
// gpc_pin_control.v: control logic of general-purpose pin 3: register
// file, pin driver, input debounce, role decode and edge interrupt.
// assumes a one-cycle register port master on core_clk and an external
// pad that resolves pinOut / pinOe_n and applies the pull enables.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defs.vh"

// Summary of operation
// - bit 7 (reset 0) tri-states the pin when clear; bit 15 (reset 1) picks output 0, input 1.
// - pull field 14:13 (reset 01) gives none 00, pull-down 01, pull-up 10 while bit 7 is set; 11 is reserved.
// - in interrupt mode 0 a rising pin edge fires at polarity 1, a falling one at polarity 0.
// - in interrupt mode 1 every rising and every falling edge fires, whatever the polarity.
// - bit 11 (reset 0) selects the buffer supply at 0 or the always-on core supply at 1.
// - bit 10 (reset 1) makes the pin active high when set and inverted when clear.
// - bit 9 (reset 0) makes the driver push-pull when clear and open-drain when set.
// - input code 0 of field 3:0 (reset 0) is a plain input with long debounce, code 1 without.
// - input codes 2 to 7 are on/off, sleep/wake, long sleep/wake, sleep, power-on, watchdog.
// - input codes 8 to 15 are two scaling, two enable, two control, two long-debounced control.
// - output codes 0 to 4 are level, 32.768kHz clock, on, sleep, state change; 5 to 7 reserved.
// - output codes 8 to 11 drive both scaling done flags and both external power enables.
// - output code 12 drives system supply good and code 13 converter power good.
// - output code 14 drives the 2MHz external power clock and code 15 the auxiliary reset.
module gpc_pin_control #(
    parameter [`GPC_DB_CNT_W-1:0] LONG_DB_CYCLES = `GPC_LONG_DB_CYC
) (
    input  wire        core_clk,       // 250 MHz block clock
    input  wire        rst_n,          // synchronous reset, active low
    input  wire [15:0] regAddr,        // register address
    input  wire [15:0] regWrData,      // register write data
    input  wire        regWrEn,        // write strobe
    input  wire        regRdEn,        // read strobe
    output reg  [15:0] regRdData,      // read data, cycle after strobe

    input  wire        pinIn,          // pad input level
    output reg         pinOut,         // pad output level
    output reg         pinOe_n,        // pad drive, low while driving
    output reg         pullUpEn,       // pad pull-up enable
    output reg         pullDownEn,     // pad pull-down enable
    output reg         ioSupplySel,    // 0 buffer supply, 1 core supply

    output reg  [15:0] inRoleReq,      // one request line per input code

    input  wire        osc32kClk,      // 32.768kHz oscillator
    input  wire        onState,        // device in on state
    input  wire        sleepState,     // device in sleep state
    input  wire        pwrStateChg,    // power state change
    input  wire        dvsDone1,       // converter 1 scaling done
    input  wire        dvsDone2,       // converter 2 scaling done
    input  wire        extPwrEn1,      // external power enable 1
    input  wire        extPwrEn2,      // external power enable 2
    input  wire        sysSupplyGood,  // system supply good
    input  wire        convPowerGood,  // converter power good
    input  wire        extPwrClk2m,    // 2MHz external power clock
    input  wire        auxReset,       // auxiliary reset

    output wire        irq             // level interrupt, active high
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // long-debounce input codes: 0, 4, 14 and 15
    function isLongDb;
        input [3:0] fn;
        begin
            isLongDb = (fn == 4'h0) || (fn == 4'h4) ||
                       (fn == 4'he) || (fn == 4'hf);
        end
    endfunction

    // address match for write and read decode
    function addrHit;
        input [15:0] addr;
        input [15:0] target;
        begin
            addrHit = (addr == target);
        end
    endfunction

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // software state
    reg  [15:0]              ctrl_r;
    reg                      outLvl_r;
    reg                      irqStat_r;
    reg                      irqMask_r;

    // debounce state
    reg                      dbLvl_r;
    reg                      dbPrev_r;
    reg  [`GPC_DB_CNT_W-1:0] dbCnt_r;

    // combinational results
    reg  [15:0]              rdData_nxt;
    reg                      outSrc;
    reg                      drvLvl;

    wire                     syncLvl;

    // control fields
    wire [3:0]               fnCode;
    wire [1:0]               pullCode;
    wire                     pinEna;
    wire                     isInput;
    wire                     polHigh;
    wire                     openDrain;
    wire                     edgeMode;

    // edge detection
    wire                     activeLvl;
    wire                     inActive;
    wire                     riseEvt;
    wire                     fallEvt;
    wire                     edgeEvt;

    // write strobes
    wire                     wrCtrl;
    wire                     wrData;
    wire                     wrStat;
    wire                     wrMask;

    // field views of the control register
    assign fnCode    = ctrl_r[`GPC_FN_HI:`GPC_FN_LO];
    assign pullCode  = ctrl_r[`GPC_PULL_HI:`GPC_PULL_LO];
    assign pinEna    = ctrl_r[`GPC_BIT_ENA];
    assign isInput   = ctrl_r[`GPC_BIT_DIR];
    assign polHigh   = ctrl_r[`GPC_BIT_POL];
    assign openDrain = ctrl_r[`GPC_BIT_OD];
    assign edgeMode  = ctrl_r[`GPC_BIT_IRQ_MODE];

    // write decode
    assign wrCtrl = regWrEn && addrHit(regAddr, `GPC_ADDR_CTRL);
    assign wrData = regWrEn && addrHit(regAddr, `GPC_ADDR_DATA);
    assign wrStat = regWrEn && addrHit(regAddr, `GPC_ADDR_IRQ_STAT);
    assign wrMask = regWrEn && addrHit(regAddr, `GPC_ADDR_IRQ_MASK);

    // ------------------------------------------------------------------
    // control, data and mask registers
    // ------------------------------------------------------------------
    // reserved bits are masked on write so they always read as zero
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_r    <= `GPC_CTRL_RESET;
            outLvl_r  <= 1'b0;
            irqMask_r <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrl_r <= regWrData & `GPC_CTRL_WMASK;
            end

            if (wrData) begin
                outLvl_r <= regWrData[`GPC_BIT_OUT_LVL];
            end

            if (wrMask) begin
                irqMask_r <= regWrData[`GPC_BIT_EDGE_EVT];
            end
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    // unmapped addresses read as zero
    always @* begin
        rdData_nxt = 16'h0000;
        if (addrHit(regAddr, `GPC_ADDR_CTRL)) begin
            rdData_nxt = ctrl_r;
        end else if (addrHit(regAddr, `GPC_ADDR_DATA)) begin
            rdData_nxt[`GPC_BIT_OUT_LVL] = outLvl_r;
            rdData_nxt[`GPC_BIT_IN_LVL]  = dbLvl_r;
        end else if (addrHit(regAddr, `GPC_ADDR_IRQ_STAT)) begin
            rdData_nxt[`GPC_BIT_EDGE_EVT] = irqStat_r;
        end else if (addrHit(regAddr, `GPC_ADDR_IRQ_MASK)) begin
            rdData_nxt[`GPC_BIT_EDGE_EVT] = irqMask_r;
        end
    end

    // data stands only in the cycle after the read strobe
    always @(posedge core_clk) begin
        if (!rst_n) begin
            regRdData <= 16'h0000;
        end else if (regRdEn) begin
            regRdData <= rdData_nxt;
        end else begin
            regRdData <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // input path: synchroniser, polarity, debounce
    // ------------------------------------------------------------------
    // the only reader of the raw pin
    gpc_sync u_sync (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .asyncIn   (pinIn),
        .syncLvl_r (syncLvl)
    );

    // inverted polarity turns a low pin into an active level
    assign activeLvl = polHigh ? syncLvl : ~syncLvl;
    assign inActive  = pinEna && isInput;

    // long debounce waits for a stable level; short follows the sync
    // a polarity flip shows up as one edge, since the level really moves
    always @(posedge core_clk) begin
        if (!rst_n) begin
            dbLvl_r <= 1'b0;
            dbCnt_r <= {`GPC_DB_CNT_W{1'b0}};
        end else if (!isLongDb(fnCode)) begin
            // short codes track the sync
            dbLvl_r <= activeLvl;
            dbCnt_r <= {`GPC_DB_CNT_W{1'b0}};
        end else if (activeLvl == dbLvl_r) begin
            // bounced back, start over
            dbCnt_r <= {`GPC_DB_CNT_W{1'b0}};
        end else if (dbCnt_r >= LONG_DB_CYCLES - 1'b1) begin
            dbLvl_r <= activeLvl;
            dbCnt_r <= {`GPC_DB_CNT_W{1'b0}};
        end else begin
            dbCnt_r <= dbCnt_r + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // input role decode
    // ------------------------------------------------------------------
    // each code owns one request line, asserted while the debounced
    // level is active; nothing is requested while the pin is an output
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_inRole
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    inRoleReq[gi] <= 1'b0;
                end else begin
                    inRoleReq[gi] <= inActive && dbLvl_r &&
                                     ({28'h0000000, fnCode} == gi);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // edge interrupt
    // ------------------------------------------------------------------
    assign riseEvt = dbLvl_r && !dbPrev_r;
    assign fallEvt = !dbLvl_r && dbPrev_r;

    // mode 0 sees only the edge into the active level
    assign edgeEvt = inActive &&
                     (edgeMode ? (riseEvt || fallEvt) : riseEvt);

    // sticky status, write one to clear; a new edge wins over the clear
    always @(posedge core_clk) begin
        if (!rst_n) begin
            dbPrev_r  <= 1'b0;
            irqStat_r <= 1'b0;
        end else begin
            dbPrev_r <= dbLvl_r;

            if (edgeEvt) begin
                irqStat_r <= 1'b1;
            end else if (wrStat && regWrData[`GPC_BIT_EDGE_EVT]) begin
                irqStat_r <= 1'b0;
            end
        end
    end

    // level, held until cleared or masked
    assign irq = irqStat_r && irqMask_r;

    // ------------------------------------------------------------------
    // output role select
    // ------------------------------------------------------------------
    // reserved codes 5 to 7 drive the inactive level
    always @* begin
        case (fnCode)
            4'h0:    outSrc = outLvl_r;
            4'h1:    outSrc = osc32kClk;
            4'h2:    outSrc = onState;
            4'h3:    outSrc = sleepState;
            4'h4:    outSrc = pwrStateChg;

            4'h8:    outSrc = dvsDone1;
            4'h9:    outSrc = dvsDone2;
            4'ha:    outSrc = extPwrEn1;
            4'hb:    outSrc = extPwrEn2;

            4'hc:    outSrc = sysSupplyGood;
            4'hd:    outSrc = convPowerGood;

            4'he:    outSrc = extPwrClk2m;
            4'hf:    outSrc = auxReset;
            default: outSrc = 1'b0;
        endcase

        // polarity applies to every role
        drvLvl = polHigh ? outSrc : ~outSrc;
    end

    // ------------------------------------------------------------------
    // pad driver and pad controls
    // ------------------------------------------------------------------
    // registered to keep the pad free of decode glitches; costs one
    // cycle of latency, so clock roles carry a 4 ns phase shift
    always @(posedge core_clk) begin
        if (!rst_n) begin
            pinOut      <= 1'b0;
            pinOe_n     <= 1'b1;
            pullUpEn    <= 1'b0;
            pullDownEn  <= 1'b0;
            ioSupplySel <= 1'b0;
        end else begin
            ioSupplySel <= ctrl_r[`GPC_BIT_SUPPLY];

            // reserved code 11 is treated as no pull
            pullUpEn    <= pinEna && (pullCode == `GPC_PULL_UP);
            pullDownEn  <= pinEna && (pullCode == `GPC_PULL_DOWN);

            if (!pinEna || isInput) begin
                pinOut  <= 1'b0;
                pinOe_n <= 1'b1;
            end else if (openDrain) begin
                // open drain only sinks; a high level releases the pad
                pinOut  <= 1'b0;
                pinOe_n <= drvLvl;
            end else begin
                pinOut  <= drvLvl;
                pinOe_n <= 1'b0;
            end
        end
    end

endmodule // gpc_pin_control

`default_nettype wire

/* File: gpc_pin_control_assertions.sv */
// gpc_pin_control_assertions.sv: port checker for the pin 3 block.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defs.vh"

module gpc_pin_control_assertions (
    input wire logic        core_clk,      // clock
    input wire logic        rst_n,         // reset, active low
    input wire logic [15:0] regAddr,       // address
    input wire logic [15:0] regWrData,     // write data
    input wire logic        regWrEn,       // write strobe
    input wire logic        regRdEn,       // read strobe
    input wire logic [15:0] regRdData,     // read data
    input wire logic        pinOut,        // pad level
    input wire logic        pinOe_n,       // pad drive, low active
    input wire logic        pullUpEn,      // pull-up
    input wire logic        pullDownEn,    // pull-down
    input wire logic        ioSupplySel,   // supply select
    input wire logic [15:0] inRoleReq,     // input roles
    input wire logic        osc32kClk,     // role sources
    input wire logic        onState,
    input wire logic        sleepState,
    input wire logic        pwrStateChg,
    input wire logic        dvsDone1,
    input wire logic        dvsDone2,
    input wire logic        extPwrEn1,
    input wire logic        extPwrEn2,
    input wire logic        sysSupplyGood,
    input wire logic        convPowerGood,
    input wire logic        extPwrClk2m,
    input wire logic        auxReset,
    input wire logic        irq            // interrupt
);
    // ------------------------------------
    // shadow of software state
    // ------------------------------------
    logic [15:0] ctrl_r;
    logic        outLvl_r;
    logic        mask_r;
    // mirror writes to predict the pad outputs
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_r   <= `GPC_CTRL_RESET;
            outLvl_r <= 1'b0;
            mask_r   <= 1'b0;
        end else if (regWrEn) begin
            if (regAddr == `GPC_ADDR_CTRL) ctrl_r <= regWrData & `GPC_CTRL_WMASK;
            if (regAddr == `GPC_ADDR_DATA) outLvl_r <= regWrData[0];
            if (regAddr == `GPC_ADDR_IRQ_MASK) mask_r <= regWrData[0];
        end
    end
    // role sources by function code, reserved give 0
    wire [15:0] srcVec = {auxReset, extPwrClk2m, convPowerGood, sysSupplyGood, extPwrEn2,
                          extPwrEn1, dvsDone2, dvsDone1, 3'h0, pwrStateChg, sleepState,
                          onState, osc32kClk, outLvl_r};
    wire        drive  = ctrl_r[7] && !ctrl_r[15];
    wire        level  = ctrl_r[10] ? srcVec[ctrl_r[3:0]] : !srcVec[ctrl_r[3:0]];
    wire        mapped = regAddr == `GPC_ADDR_CTRL || regAddr == `GPC_ADDR_DATA ||
                         regAddr == `GPC_ADDR_IRQ_STAT || regAddr == `GPC_ADDR_IRQ_MASK;

    // ------------------------------------
    // properties
    // ------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_RD_IDLE: assert property (!$past(regRdEn && mapped) |-> regRdData == 16'h0)
        else $error("stray read data");
    AST_CTRL_RDBK: assert property ($past(regRdEn && regAddr == `GPC_ADDR_CTRL)
        |-> regRdData == $past(ctrl_r)) else $error("control readback wrong");
    AST_TRISTATE: assert property ($past(!drive) |-> pinOe_n && !pinOut)
        else $error("pad driven when off");
    AST_CMOS: assert property ($past(drive && !ctrl_r[9])
        |-> !pinOe_n && pinOut == $past(level)) else $error("push-pull level wrong");
    AST_OPEN_DRAIN: assert property ($past(drive && ctrl_r[9])
        |-> !pinOut && pinOe_n == $past(level)) else $error("open-drain drive wrong");
    AST_PULL: assert property (pullUpEn == $past(ctrl_r[7] && ctrl_r[14:13] == 2'h2) &&
        pullDownEn == $past(ctrl_r[7] && ctrl_r[14:13] == 2'h1)) else $error("pull wrong");
    AST_SUPPLY: assert property (ioSupplySel == $past(ctrl_r[11]))
        else $error("supply select wrong");
    AST_ROLE: assert property (inRoleReq != 16'h0 |-> $past(ctrl_r[7] && ctrl_r[15]) &&
        inRoleReq == 16'h1 << $past(ctrl_r[3:0])) else $error("input role wrong");
    AST_IRQ_MASK: assert property (irq |-> mask_r) else $error("masked irq");
    AST_IRQ_HOLD: assert property (irq && !(regWrEn && (regAddr == `GPC_ADDR_IRQ_STAT ||
        regAddr == `GPC_ADDR_IRQ_MASK)) |=> irq) else $error("irq dropped");

    COV_IRQ: cover property ($rose(irq));
    COV_OD: cover property (drive && ctrl_r[9] && !pinOe_n);
    COV_ROLE: cover property (inRoleReq != 16'h0);
endmodule // gpc_pin_control_assertions

bind gpc_pin_control gpc_pin_control_assertions gpc_pin_control_assertions_inst (
    .core_clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .pinOut,
    .pinOe_n, .pullUpEn, .pullDownEn, .ioSupplySel, .inRoleReq, .osc32kClk, .onState,
    .sleepState, .pwrStateChg, .dvsDone1, .dvsDone2, .extPwrEn1, .extPwrEn2,
    .sysSupplyGood, .convPowerGood, .extPwrClk2m, .auxReset, .irq);
`default_nettype wire

/* File: gpc_pin_pad.sv */
// gpc_pin_pad.sv: board-side model of the pin 3 wire and pad.
// assumes a board source set by the bench.
`timescale 1ns/1ps
`default_nettype none

module gpc_pin_pad (
    input  wire logic core_clk,    // clock
    input  wire logic pinOut,      // block level
    input  wire logic pinOe_n,     // low while block drives
    input  wire logic pullUpEn,    // pull-up
    input  wire logic pullDownEn,  // pull-down
    input  wire logic extDrvEn,    // board source on
    input  wire logic extLvl,      // board source level
    output wire logic pinIn        // wire level
);
    logic float_r = 1'b0;
    // a floating wire toggles so a stale level never looks valid
    always @(posedge core_clk) begin
        float_r <= !float_r;
    end
    // block drive first, then board, then pulls, else float
    assign pinIn = !pinOe_n ? pinOut :
                   extDrvEn ? extLvl :
                   pullUpEn ? 1'b1 :
                   pullDownEn ? 1'b0 : float_r;
endmodule // gpc_pin_pad
`default_nettype wire

/* File: gpc_pin_control_tb_top.sv */
// gpc_pin_control_tb_top.sv: self-checking bench for the pin 3 block.
// assumes the design, pad and checker files.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defs.vh"

module gpc_pin_control_tb_top;
    logic        core_clk, rst_n, regWrEn, regRdEn, extDrvEn, extLvl;
    logic [15:0] regAddr, regWrData, srcPat, seen;
    wire  [15:0] regRdData, inRoleReq;
    wire         pinIn, pinOut, pinOe_n, pullUpEn, pullDownEn, ioSupplySel, irq;
    int          num_errors = 0;
    int          n_tests = 0;

    // ------------------------------------
    // instances; a short debounce keeps the run brief
    // ------------------------------------
    gpc_pin_control #(.LONG_DB_CYCLES(20'h8)) gpc_pin_control_inst (
        .core_clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .pinIn,
        .pinOut, .pinOe_n, .pullUpEn, .pullDownEn, .ioSupplySel, .inRoleReq, .irq,
        .osc32kClk(srcPat[1]), .onState(srcPat[2]), .sleepState(srcPat[3]),
        .pwrStateChg(srcPat[4]), .dvsDone1(srcPat[8]), .dvsDone2(srcPat[9]),
        .extPwrEn1(srcPat[10]), .extPwrEn2(srcPat[11]), .sysSupplyGood(srcPat[12]),
        .convPowerGood(srcPat[13]), .extPwrClk2m(srcPat[14]), .auxReset(srcPat[15]));
    gpc_pin_pad gpc_pin_pad_inst (
        .core_clk, .pinOut, .pinOe_n, .pullUpEn, .pullDownEn, .extDrvEn, .extLvl, .pinIn);

    // ------------------------------------
    // tasks
    // ------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrEn   <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1 chk("regRdData", exp, regRdData);
    endtask
    // or of role requests over n cycles
    task automatic watch(input int n);
        seen = 16'h0;
        repeat (n) begin
            @(posedge core_clk);
            #1 seen = seen | inRoleReq;
        end
    endtask
    // settle at a, clear status, move to b, check event
    task automatic edge_case(input logic [15:0] c, input logic a, input logic b,
                             input logic m, input logic e);
        extLvl <= a;
        wr(`GPC_ADDR_IRQ_MASK, {15'h0, m});
        wr(`GPC_ADDR_CTRL, c);
        ticks(20);
        wr(`GPC_ADDR_IRQ_STAT, 16'h1);
        #1 chk("irq", 16'h0, 16'(irq));
        extLvl <= b;
        ticks(20);
        #1 chk("irq", 16'(e & m), 16'(irq));
        rd(`GPC_ADDR_IRQ_STAT, {15'h0, e});
    endtask
    task automatic complete_run;
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // clock, 4 ns period
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = !core_clk;
    end
    // watchdog, ~4x the run
    initial begin
        #40000;
        num_errors++;
        complete_run;
    end

    // ------------------------------------
    // main sequence
    // ------------------------------------
    initial begin
        logic src;
        logic lvl;
        rst_n = 1'b0;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 16'h0;
        regWrData = 16'h0;
        srcPat = 16'h0;
        extDrvEn = 1'b1;
        extLvl = 1'b0;
        ticks(12);
        rst_n <= 1'b1;
        rd(`GPC_ADDR_CTRL, `GPC_CTRL_RESET);
        rd(`GPC_ADDR_IRQ_MASK, 16'h0);
        rd(16'h403b, 16'h0);
        chk("pinOe_n", 16'h1, 16'(pinOe_n));
        wr(`GPC_ADDR_CTRL, 16'hffff);
        rd(`GPC_ADDR_CTRL, `GPC_CTRL_WMASK);
        wr(`GPC_ADDR_CTRL, 16'h2000);
        ticks(2);
        #1 chk("pinOe_n", 16'h1, 16'(pinOe_n));
        chk("pullDownEn", 16'h0, 16'(pullDownEn));
        // pull codes and supply select on an enabled input
        for (int p = 0; p < 4; p++) begin
            wr(`GPC_ADDR_CTRL, 16'(32'h8080 | (p << 13) | ((p % 2) << 11)));
            ticks(2);
            #1 chk("pullUpEn", 16'(p == 2), 16'(pullUpEn));
            chk("pullDownEn", 16'(p == 1), 16'(pullDownEn));
            chk("ioSupplySel", 16'(p % 2), 16'(ioSupplySel));
            chk("pinOe_n", 16'h1, 16'(pinOe_n));
        end
        // every output role, polarity, driver and pattern
        extDrvEn <= 1'b0;
        for (int k = 0; k < 128; k++) begin
            srcPat <= k[6] ? 16'h5a3c : 16'ha5c3;
            wr(`GPC_ADDR_DATA, {15'h0, !k[6]});
            wr(`GPC_ADDR_CTRL, 16'(32'h0080 | (k[4] << 10) | (k[5] << 9) | (k % 16)));
            ticks(2);
            src = (k % 16 >= 5 && k % 16 <= 7) ? 1'b0 : srcPat[k % 16];
            lvl = k[4] ? src : !src;
            #1 chk("pinOe_n", 16'(k[5] ? lvl : 1'b0), 16'(pinOe_n));
            chk("pinOut", 16'(k[5] ? 1'b0 : lvl), 16'(pinOut));
            if (!k[5] || !lvl) chk("pinIn", 16'(lvl), 16'(pinIn));
        end
        // every input role: short pulse passes only without long debounce
        extDrvEn <= 1'b1;
        for (int f = 0; f < 16; f++) begin
            extLvl <= 1'b0;
            wr(`GPC_ADDR_CTRL, 16'(32'h8480 | f));
            ticks(20);
            extLvl <= 1'b1;
            ticks(4);
            extLvl <= 1'b0;
            watch(20);
            chk("inRoleReq", (f inside {0, 4, 14, 15}) ? 16'h0 : 16'(1 << f), seen);
            extLvl <= 1'b1;
            ticks(20);
            #1 chk("inRoleReq", 16'(1 << f), inRoleReq);
        end
        edge_case(16'h8481, 1'b0, 1'b1, 1'b1, 1'b1);
        edge_case(16'h8481, 1'b1, 1'b0, 1'b1, 1'b0);
        edge_case(16'h8081, 1'b1, 1'b0, 1'b1, 1'b1);
        edge_case(16'h8081, 1'b0, 1'b1, 1'b1, 1'b0);
        edge_case(16'h9481, 1'b1, 1'b0, 1'b1, 1'b1);
        edge_case(16'h9081, 1'b0, 1'b1, 1'b1, 1'b1);
        edge_case(16'h9481, 1'b0, 1'b1, 1'b0, 1'b1);
        edge_case(16'h8401, 1'b0, 1'b1, 1'b1, 1'b0);
        complete_run;
    end
endmodule // gpc_pin_control_tb_top
`default_nettype wire
